// ### src/dsm_pkg.sv
// constants and types for the serial mode-control register bank
package dsm_pkg;
  localparam int WORD_BITS = 16;
  localparam int IDX_MSB = 14;
  localparam int IDX_LSB = 8;
  localparam logic [6:0] IDX_LEFT_ATTEN = 7'h10;
  localparam logic [6:0] IDX_RIGHT_ATTEN = 7'h11;
  localparam logic [6:0] IDX_MUTE_CTRL = 7'h12;
  localparam logic [6:0] IDX_CONV_CTRL = 7'h13;
  localparam logic [6:0] IDX_FORMAT_CTRL = 7'h14;
  localparam logic [6:0] IDX_ZERO_CTRL = 7'h16;
  localparam logic [7:0] ATTEN_RESET = 8'hff;
  localparam logic [7:0] ATTEN_SILENT_MAX = 8'h80;
  localparam logic [7:0] MUTE_CTRL_RESET = 8'h00;
  localparam logic [7:0] CONV_CTRL_RESET = 8'h00;
  localparam logic [7:0] FORMAT_CTRL_RESET = 8'h05;
  localparam logic [7:0] ZERO_CTRL_RESET = 8'h00;
  // bit positions inside the mode registers
  localparam int MUTE_LEFT_BIT = 0;
  localparam int MUTE_RIGHT_BIT = 1;
  localparam int OVERSAMPLE_BIT = 6;
  localparam int REINIT_BIT = 7;
  localparam int CONV_LEFT_BIT = 0;
  localparam int CONV_RIGHT_BIT = 1;
  localparam int DEEMPH_EN_BIT = 4;
  localparam int DEEMPH_RATE_LSB = 5;
  localparam int FORMAT_LSB = 0;
  localparam int ROLLOFF_BIT = 5;
  localparam int PHASE_BIT = 0;
  localparam int ZPOL_BIT = 1;
  localparam int ZCOMMON_BIT = 2;
  // attenuator ramp: one step every 8 sample periods
  localparam int RAMP_SAMPLES = 8;
  localparam int SAMPLE_CNT_W = 3;

  typedef struct packed {
    logic [1:0] deemphasisRateSelect;
    logic deemphasisEnable;
    logic rightConverterDisable;
    logic leftConverterDisable;
    logic [2:0] audioFormatSelect;
    logic rolloffSelect;
    logic oversampleSelect;
    logic commonZeroFlagSelect;
    logic zeroFlagPolarity;
    logic outputPhaseInvert;
  } dsm_mode_type;
endpackage

// ### src/dsm_control_port.sv
// serial control port, mode register bank and ramping attenuators
//
// Contract
// - each write carries exactly one sixteen-bit word
// - bits fourteen to eight are the seven-bit register index
// - low byte is stored into the register chosen by index
// - latch rising after sixteen bits commits word to register
// - port is asynchronous; updates cross safely into audio domain
// - indices 10h to 14h and 16h decode; 15h absent
// - 10h and 11h hold left/right attenuation, reset all ones
// - codes 129 to 255 give 0.5*(N-255) dB
// - codes 0 to 128 give infinite attenuation
// - applied level steps 0.5 dB each 8/fS toward target
// - left and right attenuators ramp independently
// - 13h bits 1:0 disable right/left converter, reset zero
// - 13h bit 4 de-emphasis enable, bits 6:5 rate, reset zero
// - 14h bits 2:0 data format, reset 24-bit left-justified
// - 14h bit 5 rolloff, reset sharp, one selects slow
// - 16h bits 2:0 common flag, polarity, phase, reset zero
// - mute ramps down to silence and back up at same rate
// - soft reinit bit returns all registers to defaults
// - format codes: right-justified widths, I2S, left-justified default
// - disabled converter holds output at bipolar zero
module dsm_control_port
  import dsm_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic controlLatchLine,
  input wire logic controlBitClock,
  input wire logic controlSerialInput,
  input wire logic sampleClock,
  output logic [7:0] leftAppliedLevel,
  output logic [7:0] rightAppliedLevel,
  output logic leftHoldBipolarZero,
  output logic rightHoldBipolarZero,
  output dsm_mode_type modeSettings
);

  // two-stage synchronisers for the pins
  logic [2:0] latchSync_reg, latchSync_next;
  logic [2:0] bclkSync_reg, bclkSync_next;
  logic [2:0] lrSync_reg, lrSync_next;
  logic [1:0] dataSync_reg, dataSync_next;

  always_comb
  begin
    latchSync_next = {latchSync_reg[1:0], controlLatchLine};
    bclkSync_next = {bclkSync_reg[1:0], controlBitClock};
    lrSync_next = {lrSync_reg[1:0], sampleClock};
    dataSync_next = {dataSync_reg[0], controlSerialInput};
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      latchSync_reg <= 3'h7;
      bclkSync_reg <= 3'h0;
      lrSync_reg <= 3'h0;
      dataSync_reg <= 2'h0;
    end
    else
    begin
      latchSync_reg <= latchSync_next;
      bclkSync_reg <= bclkSync_next;
      lrSync_reg <= lrSync_next;
      dataSync_reg <= dataSync_next;
    end
  end

  // edge detect only on stages past the first
  logic latchLow, latchRise, bclkRise, sampleTick;
  assign latchLow = ~latchSync_reg[1];
  assign latchRise = latchSync_reg[1] & ~latchSync_reg[2];
  assign bclkRise = bclkSync_reg[1] & ~bclkSync_reg[2];
  assign sampleTick = lrSync_reg[1] & ~lrSync_reg[2];

  // shift register and bit counter
  logic [15:0] shift_reg, shift_next;
  logic [4:0] bitCount_reg, bitCount_next;
  logic commit;
  logic [6:0] writeIndex;
  logic [7:0] writeData;

  always_comb
  begin
    shift_next = shift_reg;
    bitCount_next = bitCount_reg;
    if (latchRise)
      bitCount_next = 5'h00;
    else if (latchLow && bclkRise)
    begin
      shift_next = {shift_reg[14:0], dataSync_reg[1]};
      if (bitCount_reg != 5'h1f)
        bitCount_next = bitCount_reg + 5'h01;
    end
  end

  // commit only after exactly sixteen bits
  assign commit = latchRise && (bitCount_reg == 5'(WORD_BITS));
  assign writeIndex = shift_reg[IDX_MSB:IDX_LSB];
  assign writeData = shift_reg[7:0];

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      shift_reg <= 16'h0000;
      bitCount_reg <= 5'h00;
    end
    else
    begin
      shift_reg <= shift_next;
      bitCount_reg <= bitCount_next;
    end
  end

  // mode register bank
  logic [7:0] leftCode_reg, leftCode_next;
  logic [7:0] rightCode_reg, rightCode_next;
  logic [7:0] muteCtrl_reg, muteCtrl_next;
  logic [7:0] convCtrl_reg, convCtrl_next;
  logic [7:0] formatCtrl_reg, formatCtrl_next;
  logic [7:0] zeroCtrl_reg, zeroCtrl_next;

  always_comb
  begin
    leftCode_next = leftCode_reg;
    rightCode_next = rightCode_reg;
    muteCtrl_next = muteCtrl_reg;
    convCtrl_next = convCtrl_reg;
    formatCtrl_next = formatCtrl_reg;
    zeroCtrl_next = zeroCtrl_reg;
    // reinit restores defaults; self-clears with the rest
    if (muteCtrl_reg[REINIT_BIT])
    begin
      leftCode_next = ATTEN_RESET;
      rightCode_next = ATTEN_RESET;
      muteCtrl_next = MUTE_CTRL_RESET;
      convCtrl_next = CONV_CTRL_RESET;
      formatCtrl_next = FORMAT_CTRL_RESET;
      zeroCtrl_next = ZERO_CTRL_RESET;
    end
    else if (commit)
    begin
      if (writeIndex == IDX_LEFT_ATTEN)
        leftCode_next = writeData;
      else if (writeIndex == IDX_RIGHT_ATTEN)
        rightCode_next = writeData;
      else if (writeIndex == IDX_MUTE_CTRL)
        muteCtrl_next = writeData;
      else if (writeIndex == IDX_CONV_CTRL)
        convCtrl_next = writeData;
      else if (writeIndex == IDX_FORMAT_CTRL)
        formatCtrl_next = writeData;
      else if (writeIndex == IDX_ZERO_CTRL)
        zeroCtrl_next = writeData;
    end
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      leftCode_reg <= ATTEN_RESET;
      rightCode_reg <= ATTEN_RESET;
      muteCtrl_reg <= MUTE_CTRL_RESET;
      convCtrl_reg <= CONV_CTRL_RESET;
      formatCtrl_reg <= FORMAT_CTRL_RESET;
      zeroCtrl_reg <= ZERO_CTRL_RESET;
    end
    else
    begin
      leftCode_reg <= leftCode_next;
      rightCode_reg <= rightCode_next;
      muteCtrl_reg <= muteCtrl_next;
      convCtrl_reg <= convCtrl_next;
      formatCtrl_reg <= formatCtrl_next;
      zeroCtrl_reg <= zeroCtrl_next;
    end
  end

  // codes up to 128 collapse to one silent level
  function automatic logic [7:0] effectiveLevel(input logic [7:0] code,
                                                input logic mute);
    if (mute || code <= ATTEN_SILENT_MAX)
      effectiveLevel = ATTEN_SILENT_MAX;
    else
      effectiveLevel = code;
  endfunction

  // one half-decibel step toward the target
  function automatic logic [7:0] stepToward(input logic [7:0] now,
                                            input logic [7:0] target);
    if (now < target)
      stepToward = now + 8'h01;
    else if (now > target)
      stepToward = now - 8'h01;
    else
      stepToward = now;
  endfunction

  // sample divider; step paced by sample clock so ramp stays 8/fS
  logic [SAMPLE_CNT_W-1:0] sampleCnt_reg, sampleCnt_next;
  logic rampStep;
  logic [7:0] leftLevel_reg, leftLevel_next;
  logic [7:0] rightLevel_reg, rightLevel_next;
  logic [7:0] leftTarget, rightTarget;

  assign leftTarget = effectiveLevel(leftCode_reg,
                                     muteCtrl_reg[MUTE_LEFT_BIT]);
  assign rightTarget = effectiveLevel(rightCode_reg,
                                      muteCtrl_reg[MUTE_RIGHT_BIT]);
  assign rampStep = sampleTick &&
    (sampleCnt_reg == SAMPLE_CNT_W'(RAMP_SAMPLES - 1));

  always_comb
  begin
    sampleCnt_next = sampleCnt_reg;
    leftLevel_next = leftLevel_reg;
    rightLevel_next = rightLevel_reg;
    if (sampleTick)
      sampleCnt_next = sampleCnt_reg + SAMPLE_CNT_W'(1);
    // each channel steps on its own target
    if (muteCtrl_reg[REINIT_BIT])
    begin
      leftLevel_next = ATTEN_RESET;
      rightLevel_next = ATTEN_RESET;
    end
    else if (rampStep)
    begin
      leftLevel_next = stepToward(leftLevel_reg, leftTarget);
      rightLevel_next = stepToward(rightLevel_reg, rightTarget);
    end
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      sampleCnt_reg <= '0;
      leftLevel_reg <= ATTEN_RESET;
      rightLevel_reg <= ATTEN_RESET;
    end
    else
    begin
      sampleCnt_reg <= sampleCnt_next;
      leftLevel_reg <= leftLevel_next;
      rightLevel_reg <= rightLevel_next;
    end
  end

  // registered outputs toward the audio path
  dsm_mode_type mode_next;
  dsm_mode_type mode_reg;
  logic leftZero_reg, rightZero_reg;

  always_comb
  begin
    mode_next.deemphasisRateSelect =
      convCtrl_reg[DEEMPH_RATE_LSB +: 2];
    mode_next.deemphasisEnable = convCtrl_reg[DEEMPH_EN_BIT];
    mode_next.rightConverterDisable = convCtrl_reg[CONV_RIGHT_BIT];
    mode_next.leftConverterDisable = convCtrl_reg[CONV_LEFT_BIT];
    mode_next.audioFormatSelect = formatCtrl_reg[FORMAT_LSB +: 3];
    mode_next.rolloffSelect = formatCtrl_reg[ROLLOFF_BIT];
    mode_next.oversampleSelect = muteCtrl_reg[OVERSAMPLE_BIT];
    mode_next.commonZeroFlagSelect = zeroCtrl_reg[ZCOMMON_BIT];
    mode_next.zeroFlagPolarity = zeroCtrl_reg[ZPOL_BIT];
    mode_next.outputPhaseInvert = zeroCtrl_reg[PHASE_BIT];
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      // format default shown from reset on, not one edge late
      mode_reg <= '0;
      mode_reg.audioFormatSelect <= FORMAT_CTRL_RESET[FORMAT_LSB +: 3];
      leftZero_reg <= 1'b0;
      rightZero_reg <= 1'b0;
    end
    else
    begin
      mode_reg <= mode_next;
      leftZero_reg <= mode_next.leftConverterDisable;
      rightZero_reg <= mode_next.rightConverterDisable;
    end
  end

  assign modeSettings = mode_reg;
  assign leftAppliedLevel = leftLevel_reg;
  assign rightAppliedLevel = rightLevel_reg;
  assign leftHoldBipolarZero = leftZero_reg;
  assign rightHoldBipolarZero = rightZero_reg;
endmodule

// ### testbench/dsm_control_port_asserts.sv
// port-level checks of the serial mode-control register bank
module dsm_control_port_asserts
  import dsm_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic controlLatchLine,
  input wire logic sampleClock,
  input wire logic [7:0] leftAppliedLevel,
  input wire logic [7:0] rightAppliedLevel,
  input wire logic leftHoldBipolarZero,
  input wire logic rightHoldBipolarZero,
  input wire dsm_mode_type modeSettings
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  // sample-clock rises since the last left level change, saturating
  logic [7:0] leftPrev;
  logic sampleClockPrev;
  logic [3:0] leftTicks;
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      leftPrev <= 8'hff;
      sampleClockPrev <= 1'b0;
      leftTicks <= 4'h0;
    end
    else
    begin
      leftPrev <= leftAppliedLevel;
      sampleClockPrev <= sampleClock;
      if (leftAppliedLevel != leftPrev)
        leftTicks <= 4'h0;
      else if (sampleClock && !sampleClockPrev && leftTicks != 4'hf)
        leftTicks <= leftTicks + 4'h1;
    end
  end

  // reset, ramp size and floor of the attenuators
  property p_reset_levels;
    $rose(rstn) |-> leftAppliedLevel == 8'hff && rightAppliedLevel == 8'hff;
  endproperty
  a_reset_levels: assert property (p_reset_levels)
    else $error("levels not at full scale after reset");
  property p_left_step;
    $changed(leftAppliedLevel) |-> leftAppliedLevel == 8'hff
      || leftAppliedLevel - $past(leftAppliedLevel) == 8'h01
      || $past(leftAppliedLevel) - leftAppliedLevel == 8'h01;
  endproperty
  a_left_step: assert property (p_left_step)
    else $error("left level moved by more than one step");
  property p_right_step;
    $changed(rightAppliedLevel) |-> rightAppliedLevel == 8'hff
      || rightAppliedLevel - $past(rightAppliedLevel) == 8'h01
      || $past(rightAppliedLevel) - rightAppliedLevel == 8'h01;
  endproperty
  a_right_step: assert property (p_right_step)
    else $error("right level moved by more than one step");
  // a ramp step needs eight sample periods since the previous one
  property p_left_pace;
    $changed(leftAppliedLevel) && leftAppliedLevel != 8'hff
      |-> leftTicks >= 4'h8;
  endproperty
  a_left_pace: assert property (p_left_pace)
    else $error("left step came before eight sample periods");
  property p_floor;
    leftAppliedLevel >= ATTEN_SILENT_MAX && rightAppliedLevel >= 8'h80;
  endproperty
  a_floor: assert property (p_floor)
    else $error("level below the silent code");
  // steps are spaced by eight sample periods, so never on adjacent clocks
  property p_left_gap;
    $changed(leftAppliedLevel) && leftAppliedLevel != 8'hff
      |=> $stable(leftAppliedLevel) [*8];
  endproperty
  a_left_gap: assert property (p_left_gap)
    else $error("left steps too close together");
  property p_right_gap;
    $changed(rightAppliedLevel) && rightAppliedLevel != 8'hff
      |=> $stable(rightAppliedLevel) [*8];
  endproperty
  a_right_gap: assert property (p_right_gap)
    else $error("right steps too close together");
  // settings only move after the latch has gone back high
  property p_mode_latch;
    $changed(modeSettings) |-> controlLatchLine && $past(controlLatchLine, 2);
  endproperty
  a_mode_latch: assert property (p_mode_latch)
    else $error("settings changed without a latch rise");
  property p_frame_quiet;
    $fell(controlLatchLine) |=> $stable(modeSettings) [*8];
  endproperty
  a_frame_quiet: assert property (p_frame_quiet)
    else $error("settings changed inside a frame");
  property p_hold;
    leftHoldBipolarZero == modeSettings.leftConverterDisable
      && rightHoldBipolarZero == modeSettings.rightConverterDisable;
  endproperty
  a_hold: assert property (p_hold)
    else $error("hold outputs disagree with disable bits");
endmodule

bind dsm_control_port dsm_control_port_asserts chk (
  .clock, .rstn, .controlLatchLine, .sampleClock, .leftAppliedLevel,
  .rightAppliedLevel, .leftHoldBipolarZero, .rightHoldBipolarZero,
  .modeSettings
);

// ### testbench/dsm_host_model.sv
// host side of the three-wire control port, paced off the clock's fall
module dsm_host_model
(
  input wire logic clock,
  output logic latchLine,
  output logic bitClock,
  output logic serialData
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    latchLine = 1'b1;
    bitClock = 1'b0;
    serialData = 1'b0;
  end
  // one 160 ns bit clock per bit, msb first
  task automatic send(input logic [15:0] word, input int nbits);
    @(negedge clock);
    latchLine = 1'b0;
    for (int i = 15; i > 15 - nbits; i--)
    begin
      serialData = word[i];
      repeat (4) @(negedge clock);
      bitClock = 1'b1;
      repeat (4) @(negedge clock);
      bitClock = 1'b0;
    end
    repeat (4) @(negedge clock);
    // latch rise commits; data is stale afterwards
    latchLine = 1'b1;
    serialData = ~serialData;
    repeat (12) @(negedge clock);
  endtask
endmodule

// ### testbench/dsm_control_port_tb_top.sv
// self-checking bench for the serial mode-control bank
module dsm_control_port_tb_top
  import dsm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic sampleClock = 1'b0;
  logic latchLine, bitClock, serialData, leftHold, rightHold;
  logic [7:0] leftLevel, rightLevel;
  dsm_mode_type mode, expMode;
  int bad_count = 0;
  int checks = 0;

  dsm_host_model host (.clock(clock), .latchLine(latchLine),
    .bitClock(bitClock), .serialData(serialData));
  dsm_control_port uut (.clock(clock), .rstn(rstn),
    .controlLatchLine(latchLine), .controlBitClock(bitClock),
    .controlSerialInput(serialData), .sampleClock(sampleClock),
    .leftAppliedLevel(leftLevel), .rightAppliedLevel(rightLevel),
    .leftHoldBipolarZero(leftHold), .rightHoldBipolarZero(rightHold),
    .modeSettings(mode));

  // 50 MHz clock and an unrelated 5 MHz sample clock
  initial
  begin
    forever #10 clock = ~clock;
  end
  initial
  begin
    forever #100 sampleClock = ~sampleClock;
  end

  task automatic check(input string what, input logic [15:0] exp, got);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // bit 15 zero in every word; index and data bits sent as given
  task automatic wr(input logic [6:0] idx, input logic [7:0] data);
    host.send({1'b0, idx, data}, 16);
  endtask
  // one attenuator step is 8 sample periods, 80 clocks here
  task automatic steps(input int n);
    repeat (n * 80) @(negedge clock);
  endtask
  task automatic cmode();
    check("mode", {3'h0, expMode}, {3'h0, mode});
  endtask
  task automatic stop_test();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // hang guard, well past the expected 14k clocks
  initial
  begin
    repeat (40000) @(posedge clock);
    bad_count++;
    stop_test();
  end

  initial
  begin
    repeat (5) @(negedge clock);
    rstn = 1'b1;
    repeat (3) @(negedge clock);
    expMode = '0;
    expMode.audioFormatSelect = 3'h5;
    cmode();
    check("levels", 16'hffff, {leftLevel, rightLevel});
    check("holds", 16'h0000, {14'h0, leftHold, rightHold});
    wr(IDX_CONV_CTRL, 8'h53);
    expMode.deemphasisRateSelect = 2'h2;
    expMode.deemphasisEnable = 1'b1;
    expMode.leftConverterDisable = 1'b1;
    expMode.rightConverterDisable = 1'b1;
    cmode();
    check("holds", 16'h0003, {14'h0, leftHold, rightHold});
    expMode.rolloffSelect = 1'b1;
    for (int f = 0; f < 6; f++)
    begin
      wr(IDX_FORMAT_CTRL, {5'h04, f[2:0]});
      expMode.audioFormatSelect = f[2:0];
      cmode();
    end
    wr(IDX_ZERO_CTRL, 8'h07);
    expMode.commonZeroFlagSelect = 1'b1;
    expMode.zeroFlagPolarity = 1'b1;
    expMode.outputPhaseInvert = 1'b1;
    cmode();
    wr(7'h15, 8'hff);
    cmode();
    host.send({1'b0, IDX_ZERO_CTRL, 8'h00}, 15);
    cmode();
    wr(IDX_MUTE_CTRL, 8'h40);
    expMode.oversampleSelect = 1'b1;
    cmode();
    wr(IDX_LEFT_ATTEN, 8'h84);
    check("right", 16'h00ff, {8'h0, rightLevel});
    wr(IDX_RIGHT_ATTEN, 8'h00);
    steps(132);
    check("levels", 16'h8480, {leftLevel, rightLevel});
    wr(IDX_MUTE_CTRL, 8'h41);
    steps(8);
    check("muted", 16'h8080, {leftLevel, rightLevel});
    wr(IDX_MUTE_CTRL, 8'h40);
    steps(8);
    check("unmuted", 16'h8480, {leftLevel, rightLevel});
    wr(IDX_MUTE_CTRL, 8'h80);
    expMode = '0;
    expMode.audioFormatSelect = 3'h5;
    cmode();
    check("levels", 16'hffff, {leftLevel, rightLevel});
    check("holds", 16'h0000, {14'h0, leftHold, rightHold});
    stop_test();
  end
endmodule
